// file: verilog/acc_pkg.sv
package acc_pkg;
    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0] MODE_OFFS = 8'h62;
    localparam logic [7:0] REF_OFFS = 8'h65;
    localparam logic [7:0] AVG_OFFS = 8'h68;
    localparam logic [7:0] STAT_OFFS = 8'h6a;
    // Own control register holding the global calibration enable
    localparam logic [7:0] CTRL_OFFS = 8'h61;
    // Reset values
    localparam logic [7:0] MODE_RST = 8'h01;
    localparam logic [7:0] REF_RST = 8'h01;
    localparam logic [7:0] AVG_RST = 8'h61;
    localparam logic [7:0] CTRL_RST = 8'h01;
    // Field positions
    localparam int FG_BIT = 0;
    localparam int BG_BIT = 1;
    localparam int FGOS_BIT = 2;
    localparam int BGOS_BIT = 3;
    localparam int REFSEL_BIT = 2;
    localparam int LIN_LSB = 0;
    localparam int OFS_LSB = 4;
    // Writable bit masks; reserved bits keep their reset value
    localparam logic [7:0] MODE_MASK = 8'h0f;
    localparam logic [7:0] REF_MASK = 8'h04;
    localparam logic [7:0] AVG_MASK = 8'h77;
    localparam logic [7:0] CTRL_MASK = 8'h01;

    // Settings captured when a run starts
    typedef struct packed {
        logic fg_run;
        logic bg_run;
        logic fg_os;
        logic bg_os;
        logic ref_spare;
        logic [2:0] ofs_avg;
        logic [2:0] lin_avg;
    } acc_cfg_t;

    // Status flags shown to software
    typedef struct packed {
        logic [2:0] code;
        logic stopped;
        logic fg_complete;
    } acc_stat_t;
endpackage : acc_pkg

// file: verilog/acc_top.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module acc_top #(
    parameter int FG_CYCLES = 64
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_fg_step_done,
    input wire logic i_bg_halted,
    output logic o_clear_corr,
    output logic o_fg_active,
    output logic o_bg_active,
    output acc_pkg::acc_cfg_t o_run_cfg
);
    typedef enum logic [1:0] {ACC_IDLE, ACC_CLEAR, ACC_FG, ACC_BG} acc_state_t;

    logic [7:0] mode_r, mode_nxt, ref_r, ref_nxt, avg_r, avg_nxt, ctrl_r, ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    acc_state_t state_r, state_nxt;
    acc_pkg::acc_cfg_t cfg_r, cfg_nxt;
    acc_pkg::acc_stat_t stat_r, stat_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic halt_s1_r, halt_s2_r, step_s1_r, step_s2_r;
    logic en;

    // Masked write keeps reserved bits at reset value whatever software sends
    function automatic logic [7:0] wmask(input logic [7:0] old, input logic [7:0] d,
                                         input logic [7:0] m);
        wmask = (old & ~m) | (d & m);
    endfunction : wmask

    // Analog-side handshakes come from another domain: two flops first
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            halt_s1_r <= 1'b0;
            halt_s2_r <= 1'b0;
            step_s1_r <= 1'b0;
            step_s2_r <= 1'b0;
        end else begin
            halt_s1_r <= i_bg_halted;
            halt_s2_r <= halt_s1_r;
            step_s1_r <= i_fg_step_done;
            step_s2_r <= step_s1_r;
        end
    end

    // Register writes and read data; status has no write path
    always_comb begin
        mode_nxt = mode_r;
        ref_nxt = ref_r;
        avg_nxt = avg_r;
        ctrl_nxt = ctrl_r;
        rdata_nxt = 8'h00;
        if (i_wr) begin
            unique case (i_addr)
                acc_pkg::MODE_OFFS: mode_nxt = wmask(mode_r, i_wdata, acc_pkg::MODE_MASK);
                acc_pkg::REF_OFFS: ref_nxt = wmask(ref_r, i_wdata, acc_pkg::REF_MASK);
                acc_pkg::AVG_OFFS: avg_nxt = wmask(avg_r, i_wdata, acc_pkg::AVG_MASK);
                acc_pkg::CTRL_OFFS: ctrl_nxt = wmask(ctrl_r, i_wdata, acc_pkg::CTRL_MASK);
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                acc_pkg::MODE_OFFS: rdata_nxt = mode_r;
                acc_pkg::REF_OFFS: rdata_nxt = ref_r;
                acc_pkg::AVG_OFFS: rdata_nxt = avg_r;
                acc_pkg::CTRL_OFFS: rdata_nxt = ctrl_r;
                acc_pkg::STAT_OFFS: rdata_nxt = {3'h0, stat_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_r <= acc_pkg::MODE_RST;
            ref_r <= acc_pkg::REF_RST;
            avg_r <= acc_pkg::AVG_RST;
            ctrl_r <= acc_pkg::CTRL_RST;
            rdata_r <= 8'h00;
        end else begin
            mode_r <= mode_nxt;
            ref_r <= ref_nxt;
            avg_r <= avg_nxt;
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign en = ctrl_r[0];

    // Run sequencer: clear, optional foreground, then background or stop
    always_comb begin
        state_nxt = state_r;
        cfg_nxt = cfg_r;
        stat_nxt = stat_r;
        cnt_nxt = cnt_r;
        if (!en) begin
            state_nxt = ACC_IDLE;
            stat_nxt = '0;
        end else begin
            unique case (state_r)
                ACC_IDLE: begin
                    // Snapshot settings so mid-run writes wait for next run
                    cfg_nxt.fg_run = mode_r[acc_pkg::FG_BIT];
                    cfg_nxt.bg_run = mode_r[acc_pkg::BG_BIT];
                    cfg_nxt.fg_os = mode_r[acc_pkg::FGOS_BIT] & mode_r[acc_pkg::FG_BIT];
                    cfg_nxt.bg_os = mode_r[acc_pkg::BGOS_BIT] & mode_r[acc_pkg::BG_BIT];
                    cfg_nxt.ref_spare = ref_r[acc_pkg::REFSEL_BIT];
                    cfg_nxt.ofs_avg = avg_r[acc_pkg::OFS_LSB +: 3];
                    cfg_nxt.lin_avg = avg_r[acc_pkg::LIN_LSB +: 3];
                    stat_nxt = '0;
                    state_nxt = ACC_CLEAR;
                end
                ACC_CLEAR: begin
                    cnt_nxt = 16'h0000;
                    state_nxt = cfg_r.fg_run ? ACC_FG : ACC_BG;
                    if (!cfg_r.fg_run) begin
                        stat_nxt.fg_complete = 1'b1;
                        stat_nxt.stopped = !cfg_r.bg_run;
                    end
                end
                ACC_FG: begin
                    cnt_nxt = cnt_r + 16'h0001;
                    // Finish on engine handshake or on timeout guard
                    if (step_s2_r || cnt_r == 16'(FG_CYCLES - 1)) begin
                        stat_nxt.fg_complete = 1'b1;
                        stat_nxt.stopped = !cfg_r.bg_run;
                        state_nxt = ACC_BG;
                    end
                end
                ACC_BG: begin
                    if (cfg_r.bg_run) begin
                        stat_nxt.stopped = halt_s2_r;
                    end
                end
            endcase
        end
        stat_nxt.code = {1'b0, state_r};
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ACC_IDLE;
            cfg_r <= '0;
            stat_r <= '0;
            cnt_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cfg_r <= cfg_nxt;
            stat_r <= stat_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Outputs toward the converter cores
    assign o_rdata = rdata_r;
    assign o_clear_corr = (state_r == ACC_CLEAR);
    assign o_fg_active = (state_r == ACC_FG);
    assign o_bg_active = (state_r == ACC_BG) && cfg_r.bg_run;
    assign o_run_cfg = cfg_r;

    // A run always opens with the correction clear
    property p_clear_first;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (state_r == ACC_IDLE && en) |=> o_clear_corr;
    endproperty
    a_clear_first: assert property (p_clear_first) else $error("no clear at start");

    // Clear lasts one cycle so the cores see a single pulse
    property p_clear_pulse;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_clear_corr |=> !o_clear_corr;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear held too long");

    // Foreground follows the clear when its bit was captured high
    property p_fg_start;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_clear_corr && cfg_r.fg_run && en) |=> o_fg_active;
    endproperty
    a_fg_start: assert property (p_fg_start) else $error("foreground not started");

    // A skipped foreground still reports done
    property p_skip_fg;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_clear_corr && !cfg_r.fg_run && en) |=> (stat_r.fg_complete && !o_fg_active);
    endproperty
    a_skip_fg: assert property (p_skip_fg) else $error("skip not flagged");

    // Guard ends a foreground run that the engine never finishes
    property p_fg_timeout;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_fg_active && en && cnt_r == 16'(FG_CYCLES - 1))
            |=> (!o_fg_active && stat_r.fg_complete);
    endproperty
    a_fg_timeout: assert property (p_fg_timeout) else $error("foreground never ended");

    // Engine handshake ends foreground and flags it
    property p_fg_step;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_fg_active && en && step_s2_r) |=> (!o_fg_active && stat_r.fg_complete);
    endproperty
    a_fg_step: assert property (p_fg_step) else $error("handshake ignored");

    // Background enable is taken from the mode register at run start
    property p_bg_gate;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (state_r == ACC_IDLE && en) |=> cfg_r.bg_run == $past(mode_r[acc_pkg::BG_BIT]);
    endproperty
    a_bg_gate: assert property (p_bg_gate) else $error("bg enable not captured");

    // Background only runs when its bit was captured high
    property p_bg_start;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_clear_corr && !cfg_r.fg_run && en) |=> o_bg_active == cfg_r.bg_run;
    endproperty
    a_bg_start: assert property (p_bg_start) else $error("bg start wrong");

    // Offset variants are dropped when their parent routine is off
    property p_bgos;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        cfg_r.bg_os |-> cfg_r.bg_run;
    endproperty
    a_bgos: assert property (p_bgos) else $error("bg offset without bg");

    // Foreground offset needs the foreground routine
    property p_fgos;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        cfg_r.fg_os |-> cfg_r.fg_run;
    endproperty
    a_fgos: assert property (p_fgos) else $error("fg offset without fg");

    // Reference choice is frozen at run start
    property p_ref;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (state_r == ACC_IDLE && en) |=> cfg_r.ref_spare == $past(ref_r[acc_pkg::REFSEL_BIT]);
    endproperty
    a_ref: assert property (p_ref) else $error("reference not captured");

    // Both averaging depths are frozen at run start
    property p_avg;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (state_r == ACC_IDLE && en) |=> cfg_r.ofs_avg == $past(avg_r[6:4])
            && cfg_r.lin_avg == $past(avg_r[2:0]);
    endproperty
    a_avg: assert property (p_avg) else $error("averaging not captured");

    // A status write while idle and disabled leaves it clear
    property p_stat_ro;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == acc_pkg::STAT_OFFS && !en && state_r == ACC_IDLE) |=> stat_r == '0;
    endproperty
    a_stat_ro: assert property (p_stat_ro) else $error("status written");

    // Dropping the enable parks the sequencer one cycle later
    property p_disable;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !en |=> (state_r == ACC_IDLE && !o_fg_active && !o_bg_active);
    endproperty
    a_disable: assert property (p_disable) else $error("runs while disabled");

    // Without background, finishing foreground also means stopped
    property p_stop_nobg;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (stat_r.fg_complete && !cfg_r.bg_run && en) |-> stat_r.stopped;
    endproperty
    a_stop_nobg: assert property (p_stop_nobg) else $error("stopped missing");

    // With background on, stopped follows the synced halt with one flop of lag
    property p_stop_track;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_bg_active && en) |=> stat_r.stopped == $past(halt_s2_r);
    endproperty
    a_stop_track: assert property (p_stop_track) else $error("stopped not tracking");

    // Main scenarios: full foreground, skip, timeout, halt and rerun
    c_fg_run: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_fg_active ##1 stat_r.fg_complete);
    c_skip_fg: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_clear_corr && !cfg_r.fg_run && cfg_r.bg_run);
    c_fg_timeout: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_fg_active && cnt_r == 16'(FG_CYCLES - 1));
    c_bg_halt: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_bg_active && stat_r.stopped);
    c_rerun: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !en ##1 en ##1 o_clear_corr);
endmodule : acc_top

// file: tb/acc_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
$display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module acc_top_tb;
    localparam logic [7:0] MO = acc_pkg::MODE_OFFS;
    localparam logic [7:0] RF = acc_pkg::REF_OFFS;
    localparam logic [7:0] AV = acc_pkg::AVG_OFFS;
    localparam logic [7:0] ST = acc_pkg::STAT_OFFS;
    localparam logic [7:0] CT = acc_pkg::CTRL_OFFS;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_fg_step_done = 1'b0;
    logic i_bg_halted = 1'b0;
    logic [7:0] o_rdata;
    logic o_clear_corr;
    logic o_fg_active;
    logic o_bg_active;
    acc_pkg::acc_cfg_t o_run_cfg;
    acc_pkg::acc_cfg_t exp_cfg;
    // Register model keyed by offset; reserved bits hold their reset value
    logic [7:0] regm [int];
    logic [7:0] msk [int];
    logic [7:0] v;
    int failures = 0;
    int samples_checked = 0;

    // Short foreground guard keeps each run brief
    acc_top #(.FG_CYCLES(8)) dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_fg_step_done(i_fg_step_done), .i_bg_halted(i_bg_halted),
        .o_clear_corr(o_clear_corr), .o_fg_active(o_fg_active),
        .o_bg_active(o_bg_active), .o_run_cfg(o_run_cfg));

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // Write cycle, then an idle cycle so the strobe never toggles twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        @(posedge i_core_clk);
        if (regm.exists(a)) regm[a] = (d & msk[a]) | (regm[a] & ~msk[a]);
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_core_clk);
    endtask : rd

    task automatic rchk(input logic [7:0] a);
        logic [7:0] r;
        rd(a, r);
        `CHK(r, regm.exists(a) ? regm[a] : 8'h00)
    endtask : rchk

    // One calibration run with the settings now in the model
    task automatic run(input bit pulse);
        logic [7:0] m;
        int n;
        m = regm[MO];
        exp_cfg = {m[0], m[1], m[2] & m[0], m[3] & m[1], regm[RF][2], regm[AV][6:4],
            regm[AV][2:0]};
        wr(CT, 8'h01);
        #1;
        for (n = 0; n < 10 && o_clear_corr !== 1'b1; n++) @(posedge i_core_clk) #1;
        `CHK(n < 10, 1'b1)
        @(posedge i_core_clk) #1;
        `CHK(o_run_cfg, exp_cfg)
        `CHK(o_fg_active, m[0])
        // Realign to the edge before driving; keep background bit and reserved bits
        @(posedge i_core_clk);
        wr(MO, {4'h0, ~m[3:2], m[1], ~m[0]});
        `CHK(o_run_cfg, exp_cfg)
        if (pulse) i_fg_step_done <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_fg_step_done <= 1'b0;
        #1;
        for (n = 0; n < 40 && o_fg_active !== 1'b0; n++) @(posedge i_core_clk) #1;
        `CHK(o_bg_active, m[1])
        @(posedge i_core_clk);
        // Status must ignore writes while a run is in progress
        wr(ST, 8'hff);
        rd(ST, v);
        `CHK(v, {3'h0, 3'h3, ~m[1], 1'b1})
        if (m[1]) begin
            i_bg_halted <= 1'b1;
            repeat (6) @(posedge i_core_clk);
            rd(ST, v);
            `CHK(v[1], 1'b1)
            i_bg_halted <= 1'b0;
            repeat (6) @(posedge i_core_clk);
            rd(ST, v);
            `CHK(v[1], 1'b0)
        end
        // Dropping the enable must halt both engines and clear the flags
        wr(CT, 8'h00);
        @(posedge i_core_clk) #1;
        `CHK({o_fg_active, o_bg_active}, 2'b00)
        @(posedge i_core_clk);
        rd(ST, v);
        `CHK(v, 8'h00)
    endtask : run

    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end

    // Whole run is well under a thousand cycles; this leaves ample margin
    initial begin
        #200000;
        failures++;
        end_sim();
    end

    // Main sequence
    initial begin
        regm[MO] = acc_pkg::MODE_RST;
        regm[RF] = acc_pkg::REF_RST;
        regm[AV] = acc_pkg::AVG_RST;
        regm[CT] = acc_pkg::CTRL_RST;
        msk[MO] = acc_pkg::MODE_MASK;
        msk[RF] = acc_pkg::REF_MASK;
        msk[AV] = acc_pkg::AVG_MASK;
        msk[CT] = acc_pkg::CTRL_MASK;
        void'($urandom(99892));
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        @(posedge i_core_clk);
        rchk(MO);
        rchk(RF);
        rchk(AV);
        rchk(CT);
        // Disabled and idle, status reads zero and ignores writes
        wr(CT, 8'h00);
        wr(ST, 8'hff);
        rd(ST, v);
        `CHK(v, 8'h00)
        wr(8'h70, 8'h5a);
        rchk(8'h70);
        // Every mode combination; reserved bits always carry their reset value
        for (int i = 0; i < 16; i++) begin
            wr(MO, {4'h0, 4'(i)});
            wr(RF, {5'h00, 1'($urandom) & regm[MO][1], 2'h1});
            wr(AV, 8'($urandom) & acc_pkg::AVG_MASK);
            rchk(MO);
            rchk(RF);
            rchk(AV);
            run(1'($urandom));
        end
        end_sim();
    end
endmodule : acc_top_tb
